// file: cascaded_dual_pic_ack_unit.v
`timescale 1ns/100ps
`include "pic_consts.vh"
// How it works
// - master serves lines 0-7, slave 8-15; slave output feeds master line 2
// - line 0 comes from the internal timer, line 2 is cascade only
// - each controller has its own edge/level select register
// - reset gives two-pulse ack, edge mode, normal end, cascade operation
// - command and mask ports at 20h/21h and A0h/A1h, eight bits
// - line 12 also from aux buffer full, line 13 from coprocessor error
// - priority 0,1, then 8-15, then 3-7
// - each controller keeps request and in-service registers
// - highest pending request moves into in-service during acknowledge
// - mask gates requests without blocking lower lines
// - rising request sets request bit; winner raises the processor interrupt
// - one external acknowledge pulse makes two internal acknowledge cycles
// - internal acknowledge sequence runs on the clock, one idle cycle between the two pulses
// - first acknowledge freezes, sets in-service, clears request, no data
// - master sends slave code after first pulse; slave compares identity
// - second acknowledge drives the eight-bit vector from the responder
// - auto end clears in-service after second pulse; else end command
// - request gone at acknowledge gives spurious level 7
// - vector holds base in bits 7-3 and line number in 2-0
// - command write with bit 4 starts init; three mask-port writes follow
// - init start clears mask, slave id 7, selects request reads
module cascaded_dual_pic_ack_unit (
  input wire clock,
  input wire reset_n,
  input wire [15:0] irq_pins,
  input wire timer_out,
  input wire aux_buffer_full,
  input wire coprocessor_error_n,
  input wire acknowledge_pulse_n,
  input wire [15:0] io_address,
  input wire io_write,
  input wire io_read,
  input wire [7:0] io_write_data,
  output reg [7:0] io_read_data,
  output reg io_read_valid,
  output reg cpu_interrupt_request,
  output reg [7:0] ack_vector,
  output reg ack_vector_valid
);
  localparam ACK_IDLE = 3'h0;
  localparam ACK_FIRST = 3'h1;
  localparam ACK_GAP = 3'h2;
  localparam ACK_SECOND = 3'h3;
  localparam ACK_DONE = 3'h4;
  localparam ACK_WAIT = 3'h5;
  reg [15:0] pins_meta_q;
  reg [15:0] pins_sync_q;
  reg [2:0] side_meta_q;
  reg [2:0] side_sync_q;
  reg ack_meta_q;
  reg ack_sync_q;
  reg ack_prev_q;
  reg [2:0] ack_state_q;
  reg [2:0] ack_state_d;
  wire slave_int;
  wire [2:0] cascade_bus;
  wire [7:0] m_cmd_read;
  wire [7:0] m_mask_read;
  wire [7:0] m_trig_read;
  wire [7:0] s_cmd_read;
  wire [7:0] s_mask_read;
  wire [7:0] s_trig_read;
  wire m_int;
  wire m_vec_valid;
  wire s_vec_valid;
  wire [7:0] m_vector;
  wire [7:0] s_vector;
  wire [7:0] master_lines;
  wire [7:0] slave_lines;
  wire ack_first;
  wire ack_second;
  wire ack_end;
  wire ack_start;
  // external sources pass two flip-flops before use
  always @(posedge clock) begin
    if (!reset_n) begin
      pins_meta_q <= 16'h0000;
      pins_sync_q <= 16'h0000;
      side_meta_q <= 3'h0;
      side_sync_q <= 3'h0;
      ack_meta_q <= 1'b1;
      ack_sync_q <= 1'b1;
      ack_prev_q <= 1'b1;
    end else begin
      pins_meta_q <= irq_pins;
      pins_sync_q <= pins_meta_q;
      side_meta_q <= {timer_out, aux_buffer_full, ~coprocessor_error_n};
      side_sync_q <= side_meta_q;
      ack_meta_q <= acknowledge_pulse_n;
      ack_sync_q <= ack_meta_q;
      ack_prev_q <= ack_sync_q;
    end
  end
  // line routing: timer on 0, slave output on 2, internal sources on 12 and 13
  assign master_lines = {pins_sync_q[7:3], slave_int, pins_sync_q[1], side_sync_q[2]};
  assign slave_lines = {pins_sync_q[15:14], pins_sync_q[13] | side_sync_q[0],
    pins_sync_q[12] | side_sync_q[1], pins_sync_q[11:8]};
  assign ack_start = ack_prev_q & ~ack_sync_q;
  // acknowledge sequencer: two one-cycle internal pulses per external pulse
  always @* begin
    ack_state_d = ack_state_q;
    case (ack_state_q)
      ACK_IDLE: begin
        if (ack_start) begin
          ack_state_d = ACK_FIRST;
        end
      end
      ACK_FIRST: begin
        ack_state_d = ACK_GAP;
      end
      ACK_GAP: begin
        ack_state_d = ACK_SECOND;
      end
      ACK_SECOND: begin
        ack_state_d = ACK_DONE;
      end
      ACK_DONE: begin
        ack_state_d = ACK_WAIT;
      end
      ACK_WAIT: begin
        if (ack_sync_q) begin
          ack_state_d = ACK_IDLE;
        end
      end
      default: begin
        ack_state_d = ACK_IDLE;
      end
    endcase
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      ack_state_q <= ACK_IDLE;
    end else begin
      ack_state_q <= ack_state_d;
    end
  end
  // internal pulses stay inside the block
  assign ack_first = (ack_state_q == ACK_FIRST);
  assign ack_second = (ack_state_q == ACK_SECOND);
  assign ack_end = (ack_state_q == ACK_DONE);
  // master controller, lines 0-7
  pic_core master_controller (
    .clock(clock),
    .reset_n(reset_n),
    .request_lines(master_lines),
    .cmd_write(io_write && io_address == `MASTER_COMMAND_PORT),
    .mask_write(io_write && io_address == `MASTER_MASK_PORT),
    .trig_write(io_write && io_address == `MASTER_TRIGGER_SELECT),
    .write_data(io_write_data),
    .ack_first(ack_first),
    .ack_second(ack_second),
    .ack_end(ack_end),
    .is_slave(1'b0),
    .cascade_in(3'h0),
    .interrupt_out(m_int),
    .cmd_read(m_cmd_read),
    .mask_read(m_mask_read),
    .trig_read(m_trig_read),
    .cascade_out(cascade_bus),
    .vector_valid(m_vec_valid),
    .vector(m_vector)
  );
  // slave controller, lines 8-15, priority inserted at master line 2
  pic_core slave_controller (
    .clock(clock),
    .reset_n(reset_n),
    .request_lines(slave_lines),
    .cmd_write(io_write && io_address == `SLAVE_COMMAND_PORT),
    .mask_write(io_write && io_address == `SLAVE_MASK_PORT),
    .trig_write(io_write && io_address == `SLAVE_TRIGGER_SELECT),
    .write_data(io_write_data),
    .ack_first(ack_first),
    .ack_second(ack_second),
    .ack_end(ack_end),
    .is_slave(1'b1),
    .cascade_in(cascade_bus),
    .interrupt_out(slave_int),
    .cmd_read(s_cmd_read),
    .mask_read(s_mask_read),
    .trig_read(s_trig_read),
    .cascade_out(),
    .vector_valid(s_vec_valid),
    .vector(s_vector)
  );
  // processor interrupt and vector return
  always @(posedge clock) begin
    if (!reset_n) begin
      cpu_interrupt_request <= 1'b0;
      ack_vector <= 8'h00;
      ack_vector_valid <= 1'b0;
    end else begin
      cpu_interrupt_request <= m_int;
      ack_vector_valid <= m_vec_valid | s_vec_valid;
      if (s_vec_valid) begin
        ack_vector <= s_vector;
      end else if (m_vec_valid) begin
        ack_vector <= m_vector;
      end
    end
  end
  // i/o read: read-back registers settle one cycle after the access
  always @(posedge clock) begin
    if (!reset_n) begin
      io_read_data <= 8'h00;
      io_read_valid <= 1'b0;
    end else begin
      io_read_valid <= io_read;
      case (io_address)
        `MASTER_COMMAND_PORT: io_read_data <= m_cmd_read;
        `MASTER_MASK_PORT: io_read_data <= m_mask_read;
        `MASTER_TRIGGER_SELECT: io_read_data <= m_trig_read;
        `SLAVE_COMMAND_PORT: io_read_data <= s_cmd_read;
        `SLAVE_MASK_PORT: io_read_data <= s_mask_read;
        `SLAVE_TRIGGER_SELECT: io_read_data <= s_trig_read;
        default: io_read_data <= 8'h00;
      endcase
    end
  end
endmodule // cascaded_dual_pic_ack_unit

// file: cascaded_dual_pic_ack_unit_bench.sv
`timescale 1ns/100ps
module cascaded_dual_pic_ack_unit_bench;
  reg clock, reset_n, timer_out, aux_buffer_full, coprocessor_error_n, io_write, io_read, fire;
  reg [15:0] irq_pins, io_address;
  reg [7:0] io_write_data, mbase, sbase, v;
  reg [3:0] low_cycles;
  reg [31:0] seed;
  wire [7:0] io_read_data, ack_vector;
  wire io_read_valid, cpu_interrupt_request, ack_vector_valid, acknowledge_pulse_n;
  integer mismatches, compares, i, k;
  cascaded_dual_pic_ack_unit cascaded_dual_pic_ack_unit_inst (.clock(clock), .reset_n(reset_n),
    .irq_pins(irq_pins), .timer_out(timer_out), .aux_buffer_full(aux_buffer_full),
    .coprocessor_error_n(coprocessor_error_n), .acknowledge_pulse_n(acknowledge_pulse_n),
    .io_address(io_address), .io_write(io_write), .io_read(io_read), .io_write_data(io_write_data),
    .io_read_data(io_read_data), .io_read_valid(io_read_valid), .cpu_interrupt_request(cpu_interrupt_request),
    .ack_vector(ack_vector), .ack_vector_valid(ack_vector_valid));
  host_bridge_model host_bridge_model_inst (.clock(clock), .reset_n(reset_n), .fire(fire),
    .low_cycles(low_cycles), .acknowledge_pulse_n(acknowledge_pulse_n));
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task fin(input string name);
    $display("end of %0s", name);
  endtask
  // bus cycles, driven at the falling edge
  task wr(input [15:0] a, input [7:0] d);
    @(negedge clock);
    io_address = a;
    io_write_data = d;
    io_write = 1'b1;
    @(negedge clock);
    io_write = 1'b0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(negedge clock);
    io_address = a;
    io_read = 1'b1;
    @(negedge clock);
    chk({7'h0, io_read_valid}, 8'h01);
    chk(io_read_data, e);
    io_read = 1'b0;
  endtask
  task src(input integer n, input b);
    case (n)
      0: timer_out = b;
      12: aux_buffer_full = b;
      13: coprocessor_error_n = !b;
      default: irq_pins[n] = b;
    endcase
  endtask
  task init(input [15:0] a, input [7:0] base, input [7:0] w3, input [7:0] w4);
    wr(a, 8'h11);
    wr(a + 16'h0001, base);
    wr(a + 16'h0001, w3);
    wr(a + 16'h0001, w4);
  endtask
  // model: first pending unmasked line in priority order 0,1,8-15,3-7
  function integer pick(input [15:0] p, input [15:0] m);
    integer j, n;
    pick = -1;
    for (j = 14; j >= 0; j = j - 1) begin
      n = (j < 2) ? j : (j < 10) ? j + 6 : j - 7;
      if (p[n] && !m[n]) pick = n;
    end
  endfunction
  function [7:0] ev(input integer n);
    ev = (n < 0) ? {mbase[7:3], 3'h7} : (n < 8) ? {mbase[7:3], n[2:0]} : {sbase[7:3], n[2:0]};
  endfunction
  task ack(input [7:0] e);
    @(negedge clock);
    fire <= 1'b1;
    @(negedge clock);
    fire <= 1'b0;
    k = 0;
    while (ack_vector_valid !== 1'b1 && k < 30) begin
      @(negedge clock);
      k = k + 1;
    end
    chk({7'h0, ack_vector_valid}, 8'h01);
    chk(ack_vector, e);
    repeat (8) @(negedge clock);
  endtask
  task irq_is(input b);
    repeat (8) @(negedge clock);
    chk({7'h0, cpu_interrupt_request}, {7'h0, b});
  endtask
  // watchdog
  initial begin
    #(25 * 40000);
    mismatches = mismatches + 1;
    test_done;
  end
  // main sequence
  initial begin
    {timer_out, aux_buffer_full, io_write, io_read, fire, reset_n} = 6'h00;
    {irq_pins, io_address, io_write_data} = 40'h0;
    coprocessor_error_n = 1'b1;
    seed = 32'h48fa_d2d6;
    {mismatches, compares} = 64'h0;
    {low_cycles, mbase, sbase} = {4'h2, 8'h08, 8'h70};
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    rd(16'h0021, 8'h00);
    rd(16'h04d0, 8'h00);
    rd(16'h04d1, 8'h00);
    rd(16'h0030, 8'h00);
    fin("reset");
    init(16'h00a0, sbase, 8'h02, 8'h01);
    init(16'h0020, mbase, 8'h04, 8'h01);
    rd(16'h00a1, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      wr(16'h04d0 + i[0], v);
      rd(16'h04d0 + i[0], v);
      v = $random(seed);
      wr(16'h0021 + {i[0], 7'h0}, v);
      rd(16'h0021 + {i[0], 7'h0}, v);
    end
    for (i = 0; i < 4; i = i + 1) wr(i[1] ? 16'h04d0 + i[0] : 16'h0021 + {i[0], 7'h0}, 8'h00);
    fin("registers");
    for (i = 0; i < 16; i = i + 1) if (i != 2) begin
      low_cycles = i[0] ? 4'h2 : 4'h6;
      src(i, 1'b1);
      irq_is(1'b1);
      ack(ev(pick(16'h0001 << i, 16'h0000)));
      src(i, 1'b0);
      if (i > 7) wr(16'h00a0, 8'h20);
      wr(16'h0020, 8'h20);
      irq_is(1'b0);
    end
    fin("lines");
    src(3, 1'b1);
    src(9, 1'b1);
    irq_is(1'b1);
    ack(ev(pick(16'h0208, 16'h0000)));
    irq_is(1'b0);
    wr(16'h00a0, 8'h20);
    wr(16'h0020, 8'h20);
    ack(ev(pick(16'h0008, 16'h0000)));
    {irq_pins[3], irq_pins[9]} = 2'b00;
    wr(16'h0020, 8'h63);
    wr(16'h0020, 8'h0b);
    rd(16'h0020, 8'h00);
    wr(16'h0020, 8'h0a);
    fin("priority");
    wr(16'h0021, 8'h02);
    src(1, 1'b1);
    src(5, 1'b1);
    irq_is(1'b1);
    ack(ev(pick(16'h0022, 16'h0002)));
    wr(16'h0020, 8'h0b);
    rd(16'h0020, 8'h20);
    wr(16'h0020, 8'h0a);
    rd(16'h0020, 8'h02);
    wr(16'h0020, 8'h20);
    wr(16'h0021, 8'h00);
    irq_is(1'b1);
    ack(ev(1));
    {irq_pins[1], irq_pins[5]} = 2'b00;
    wr(16'h0020, 8'h20);
    fin("mask");
    init(16'h0020, mbase, 8'h04, 8'h03);
    src(4, 1'b1);
    irq_is(1'b1);
    ack(ev(4));
    src(4, 1'b0);
    wr(16'h0020, 8'h0b);
    rd(16'h0020, 8'h00);
    wr(16'h0020, 8'h0a);
    fin("auto end");
    wr(16'h04d0, 8'h10);
    src(4, 1'b1);
    irq_is(1'b1);
    src(4, 1'b0);
    irq_is(1'b0);
    ack(ev(-1));
    fin("spurious");
    test_done;
  end
endmodule // cascaded_dual_pic_ack_unit_bench

// file: host_bridge_model.sv
`timescale 1ns/100ps
// far side: one acknowledge pulse per bench request, short or long
module host_bridge_model (
  input wire clock,
  input wire reset_n,
  input wire fire,
  input wire [3:0] low_cycles,
  output reg acknowledge_pulse_n = 1'b1
);
  reg [3:0] left_q;
  // hold the pin low for low_cycles cycles, then release it high
  always @(negedge clock) begin
    if (!reset_n) begin
      left_q <= 4'h0;
      acknowledge_pulse_n <= 1'b1;
    end else if (fire) begin
      left_q <= low_cycles;
      acknowledge_pulse_n <= 1'b0;
    end else if (left_q > 4'h1) begin
      left_q <= left_q - 4'h1;
    end else begin
      left_q <= 4'h0;
      acknowledge_pulse_n <= 1'b1;
    end
  end
endmodule // host_bridge_model

// file: pic_ack_props.sv
`timescale 1ns/100ps
module pic_ack_props (
  input wire clock,
  input wire reset_n,
  input wire [15:0] irq_pins,
  input wire timer_out,
  input wire aux_buffer_full,
  input wire coprocessor_error_n,
  input wire acknowledge_pulse_n,
  input wire [15:0] io_address,
  input wire io_write,
  input wire io_read,
  input wire [7:0] io_write_data,
  input wire [7:0] io_read_data,
  input wire io_read_valid,
  input wire cpu_interrupt_request,
  input wire [7:0] ack_vector,
  input wire ack_vector_valid
);
  reg [3:0] since_low_q;
  wire [3:0] since_low_d;
  wire mapped;
  // cycles since the acknowledge pin was last low, saturating
  assign since_low_d = !acknowledge_pulse_n ? 4'h0 : (since_low_q == 4'hf) ? since_low_q : since_low_q + 4'h1;
  assign mapped = ((io_address & 16'hff7e) == 16'h0020) || ((io_address & 16'hfffe) == 16'h04d0);
  always @(posedge clock) begin
    if (!reset_n) since_low_q <= 4'hf;
    else since_low_q <= since_low_d;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_trig_wr; io_write && io_address == 16'h04d0; endsequence
  sequence s_trig_rd; !io_write ##1 io_read && io_address == 16'h04d0; endsequence
  sequence s_ack_start; $fell(acknowledge_pulse_n); endsequence
  property p_trig_back; s_trig_wr ##1 s_trig_rd |=> io_read_data == $past(io_write_data, 3); endproperty
  property p_rd_valid; io_read |=> io_read_valid; endproperty
  property p_rd_cause; io_read_valid |-> $past(io_read); endproperty
  property p_unmapped; io_read && !mapped |=> io_read_data == 8'h00; endproperty
  property p_ack_bound; s_ack_start |-> ##[2:12] ack_vector_valid; endproperty
  property p_ack_cause; ack_vector_valid |-> since_low_q <= 4'hb; endproperty
  property p_vec_pulse; ack_vector_valid |=> !ack_vector_valid; endproperty
  property p_vec_hold; !ack_vector_valid |-> $stable(ack_vector); endproperty
  a_trig_back: assert property (p_trig_back) else $error("trigger select read-back differs");
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered next cycle");
  a_rd_cause: assert property (p_rd_cause) else $error("read valid without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_ack_bound: assert property (p_ack_bound) else $error("acknowledge sequence too slow");
  a_ack_cause: assert property (p_ack_cause) else $error("vector without acknowledge");
  a_vec_pulse: assert property (p_vec_pulse) else $error("vector valid longer than a cycle");
  a_vec_hold: assert property (p_vec_hold) else $error("vector changed while not valid");
endmodule // pic_ack_props
bind cascaded_dual_pic_ack_unit pic_ack_props pic_ack_props_inst (.clock(clock), .reset_n(reset_n),
  .irq_pins(irq_pins), .timer_out(timer_out), .aux_buffer_full(aux_buffer_full),
  .coprocessor_error_n(coprocessor_error_n), .acknowledge_pulse_n(acknowledge_pulse_n),
  .io_address(io_address), .io_write(io_write), .io_read(io_read), .io_write_data(io_write_data),
  .io_read_data(io_read_data), .io_read_valid(io_read_valid), .cpu_interrupt_request(cpu_interrupt_request),
  .ack_vector(ack_vector), .ack_vector_valid(ack_vector_valid));

// file: pic_consts.vh
`ifndef PIC_CONSTS_VH
`define PIC_CONSTS_VH
// i/o port addresses
`define MASTER_COMMAND_PORT 16'h0020
`define MASTER_MASK_PORT 16'h0021
`define SLAVE_COMMAND_PORT 16'h00a0
`define SLAVE_MASK_PORT 16'h00a1
`define MASTER_TRIGGER_SELECT 16'h04d0
`define SLAVE_TRIGGER_SELECT 16'h04d1
// command byte fields
`define INIT_START_BIT 4
`define OCW_SEL_BIT 3
`define EOI_BIT 5
`define SPECIFIC_BIT 6
`define READ_REG_BIT 1
`define READ_ISR_BIT 0
`define AUTO_END_OF_INTERRUPT_BIT 1
`define UPM_BIT 0
// reset values
`define TRIGGER_RESET 8'h00
`define MASK_RESET 8'h00
`define SLAVE_ID_RESET 3'h7
`define SPURIOUS_LEVEL 3'h7
// cascade input of the master
`define CASCADE_LINE 2
// init sequence steps
`define STEP_IDLE 2'h0
`define STEP_TWO 2'h1
`define STEP_THREE 2'h2
`define STEP_FOUR 2'h3
// acknowledge sequencer width of each internal pulse, in cycles
`define ACK_PULSE_CYCLES 1
`endif

// file: pic_core.v
`timescale 1ns/100ps
`include "pic_consts.vh"
// one eight-line controller core
module pic_core (
  input wire clock,
  input wire reset_n,
  input wire [7:0] request_lines,
  input wire cmd_write,
  input wire mask_write,
  input wire trig_write,
  input wire [7:0] write_data,
  input wire ack_first,
  input wire ack_second,
  input wire ack_end,
  input wire is_slave,
  input wire [2:0] cascade_in,
  output reg interrupt_out,
  output reg [7:0] cmd_read,
  output reg [7:0] mask_read,
  output reg [7:0] trig_read,
  output reg [2:0] cascade_out,
  output reg vector_valid,
  output reg [7:0] vector
);
  reg [7:0] request_register_q;
  reg [7:0] in_service_register_q;
  reg [7:0] mask_register_q;
  reg [7:0] trigger_q;
  reg [7:0] line_prev_q;
  reg [4:0] vector_base_bits_q;
  reg [7:0] init_word_three_q;
  reg auto_end_of_interrupt_q;
  reg read_isr_q;
  reg [1:0] step_q;
  reg [2:0] acked_level_q;
  reg responding_q;
  reg [7:0] edge_set;
  reg [7:0] pending;
  reg [7:0] win_onehot;
  reg [2:0] win_level;
  reg win_any;
  reg [7:0] isr_top;
  integer i;
  integer j;
  // edge and level request capture
  always @* begin
    for (j = 0; j < 8; j = j + 1) begin
      edge_set[j] = trigger_q[j] ? request_lines[j] : (request_lines[j] & ~line_prev_q[j]);
    end
  end
  // priority: line 0 highest, masked lines skipped without blocking lower ones
  always @* begin
    pending = request_register_q & ~mask_register_q;
    win_onehot = 8'h00;
    win_level = `SPURIOUS_LEVEL;
    win_any = 1'b0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        win_onehot = 8'h00;
        win_onehot[i] = 1'b1;
        win_level = i[2:0];
        win_any = 1'b1;
      end
    end
    isr_top = 8'h00;
    for (i = 7; i >= 0; i = i - 1) begin
      if (in_service_register_q[i]) begin
        isr_top = 8'h00;
        isr_top[i] = 1'b1;
      end
    end
  end
  // registers, init sequence and acknowledge handling
  always @(posedge clock) begin
    if (!reset_n) begin
      request_register_q <= 8'h00;
      in_service_register_q <= 8'h00;
      mask_register_q <= `MASK_RESET;
      trigger_q <= `TRIGGER_RESET;
      line_prev_q <= 8'h00;
      vector_base_bits_q <= 5'h00;
      init_word_three_q <= {5'h00, `SLAVE_ID_RESET};
      auto_end_of_interrupt_q <= 1'b0;
      read_isr_q <= 1'b0;
      step_q <= `STEP_IDLE;
      acked_level_q <= `SPURIOUS_LEVEL;
      responding_q <= 1'b0;
      interrupt_out <= 1'b0;
      cascade_out <= 3'h0;
      vector_valid <= 1'b0;
      vector <= 8'h00;
    end else begin
      line_prev_q <= request_lines;
      vector_valid <= 1'b0;
      // request register updates freeze during the first acknowledge
      if (!ack_first) begin
        // level lines follow the pin; edge lines hold while the pin stays high
        request_register_q <= ((request_register_q & ~trigger_q) | edge_set) & request_lines;
      end
      interrupt_out <= win_any & ~|(isr_top & (win_onehot - 8'h01 | win_onehot));
      if (cmd_write && write_data[`INIT_START_BIT]) begin
        mask_register_q <= `MASK_RESET;
        init_word_three_q <= {5'h00, `SLAVE_ID_RESET};
        read_isr_q <= 1'b0;
        request_register_q <= 8'h00;
        in_service_register_q <= 8'h00;
        line_prev_q <= request_lines;
        step_q <= `STEP_TWO;
      end else if (cmd_write && !write_data[`OCW_SEL_BIT] && write_data[`EOI_BIT]) begin
        // end_of_interrupt_command: specific or lowest-numbered (highest priority) set bit
        if (write_data[`SPECIFIC_BIT]) begin
          in_service_register_q[write_data[2:0]] <= 1'b0;
        end else begin
          in_service_register_q <= in_service_register_q & ~isr_top;
        end
      end else if (cmd_write && write_data[`OCW_SEL_BIT] && write_data[`READ_REG_BIT]) begin
        read_isr_q <= write_data[`READ_ISR_BIT];
      end else if (mask_write) begin
        case (step_q)
          `STEP_TWO: begin
            vector_base_bits_q <= write_data[7:3];
            step_q <= `STEP_THREE;
          end
          `STEP_THREE: begin
            init_word_three_q <= write_data;
            step_q <= `STEP_FOUR;
          end
          `STEP_FOUR: begin
            auto_end_of_interrupt_q <= write_data[`AUTO_END_OF_INTERRUPT_BIT];
            step_q <= `STEP_IDLE;
          end
          default: begin
            mask_register_q <= write_data;
          end
        endcase
      end
      if (trig_write) begin
        trigger_q <= write_data;
      end
      // first acknowledge: set in-service, clear request, drive no data
      if (ack_first) begin
        acked_level_q <= win_level;
        if (win_any) begin
          in_service_register_q <= in_service_register_q | win_onehot;
          request_register_q <= request_register_q & ~win_onehot;
        end
        // master issues cascade code at the trailing edge of the first pulse
        cascade_out <= (win_any && init_word_three_q[win_level]) ? win_level : 3'h0;
        responding_q <= ~(win_any && init_word_three_q[win_level]);
      end
      // slave compares the cascade code with its identity
      if (ack_second) begin
        if (is_slave) begin
          responding_q <= (cascade_in == init_word_three_q[2:0]);
          vector_valid <= (cascade_in == init_word_three_q[2:0]);
        end else begin
          vector_valid <= responding_q;
        end
        vector <= {vector_base_bits_q, acked_level_q};
      end
      if (ack_end && auto_end_of_interrupt_q && (responding_q || !is_slave)) begin
        in_service_register_q[acked_level_q] <= 1'b0;
      end
    end
  end
  // register read-back
  always @(posedge clock) begin
    if (!reset_n) begin
      cmd_read <= 8'h00;
      mask_read <= 8'h00;
      trig_read <= 8'h00;
    end else begin
      cmd_read <= read_isr_q ? in_service_register_q : request_register_q;
      mask_read <= mask_register_q;
      trig_read <= trigger_q;
    end
  end
endmodule // pic_core
